// *** inc/sfs_defines.vh ***
// Constants for the servo position feedback and scaling block.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
//
// Summary of operation
// - In-position flag asserts while deviation is within the window; movement-finish also needs no start held.
// - Window unit select switches the window to encoder output pulse units.
// - Positive torque (CCW drive, CW regen) clamps to forward limit; zero gives none.
// - Negative torque (CW drive, CCW regen) clamps to reverse limit; zero gives none.
// - Torque monitor full scale equals the smaller of the two limits.
// - Direction zero: forward start runs CCW, reverse CW; one inverts both.
// - Direction and feedback pulse setting take effect only after reset.
// - A/B pulses emitted are one quarter of the scaled edge count.
// - Pulse designation mode: setting is edges per motor revolution.
// - Division ratio mode: resolution per revolution divided by the setting.
// - Command unit mode: feedback edges follow the incoming command pulses.
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SFS_ADDR_TUNING     8'h00
`define SFS_ADDR_WINDOW     8'h04
`define SFS_ADDR_FWD_LIM    8'h08
`define SFS_ADDR_REV_LIM    8'h0c
`define SFS_ADDR_DIR        8'h10
`define SFS_ADDR_FB_SCALE   8'h14
`define SFS_ADDR_CTRL       8'h18
`define SFS_ADDR_STATE      8'h1c
`define SFS_ADDR_IRQ_STAT   8'h20
`define SFS_ADDR_IRQ_MASK   8'h24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFS_RST_TUNING      16'h000c
`define SFS_RST_WINDOW      16'h0064
`define SFS_RST_TORQUE_LIM  16'h03e8
`define SFS_RST_DIR         16'h0000
`define SFS_RST_FB_SCALE    16'h0fa0
`define SFS_RST_CTRL        16'h0000

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define SFS_CTRL_OSEL_LSB   0
`define SFS_CTRL_OSEL_MSB   1
`define SFS_CTRL_WUNIT      2
`define SFS_OSEL_PULSE      2'h0
`define SFS_OSEL_DIVIDE     2'h1
`define SFS_OSEL_COMMAND    2'h2
`define SFS_IRQ_INPOS       0
`define SFS_IRQ_CLAMP       1
`define SFS_IRQ_RELOAD      2

// Encoder edges per revolution, and full scale of the torque monitor
`define SFS_ENC_RES         19'h40000
`define SFS_MON_FULL        32'h00007fff

`endif

// *** hdl/sfs_servo_feedback.v ***
// Servo position feedback scaling, in-position window, torque clamp.
// Assumes deviation, torque and step inputs come from logic on clock;
// start commands and controller reset are pins and get synchronised.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "sfs_defines.vh"

module sfs_servo_feedback (
    input  wire               clock,
    input  wire               rst_n,
    input  wire [7:0]         regAddr,
    input  wire [31:0]        regWrData,
    input  wire               regWr,
    input  wire               regRd,
    output reg  [31:0]        regRdData,
    input  wire signed [31:0] cmdDeviation,
    input  wire signed [31:0] encDeviation,
    input  wire               encStep,
    input  wire               encStepCcw,
    input  wire               cmdStep,
    input  wire               cmdStepCcw,
    input  wire               forwardStartCmd,
    input  wire               reverseStartCmd,
    input  wire               controllerReset,
    input  wire signed [15:0] torqueCmd,
    output reg  signed [15:0] torqueOut,
    output reg  [15:0]        torqueMonitor,
    output reg                inPositionFlag,
    output reg                movementFinishFlag,
    output reg                motorRunCcw,
    output reg                motorRunCw,
    output reg                feedbackA,
    output reg                feedbackB,
    output reg                irq
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Pins are asynchronous; two stages before any logic reads them
    reg [1:0] fwdSync_reg;
    reg [1:0] revSync_reg;
    reg [1:0] crstSync_reg;
    reg       crstLast_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fwdSync_reg  <= 2'h0;
            revSync_reg  <= 2'h0;
            crstSync_reg <= 2'h0;
            crstLast_reg <= 1'b0;
        end else begin
            fwdSync_reg  <= {fwdSync_reg[0], forwardStartCmd};
            revSync_reg  <= {revSync_reg[0], reverseStartCmd};
            crstSync_reg <= {crstSync_reg[0], controllerReset};
            crstLast_reg <= crstSync_reg[1];
        end
    end

    wire fwdStart   = fwdSync_reg[1];
    wire revStart   = revSync_reg[1];
    wire crstEvent  = crstSync_reg[1] & ~crstLast_reg;

    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    reg [15:0] tuningResponse_reg;
    reg [15:0] inPositionWindow_reg;
    reg [15:0] forwardTorqueLimit_reg;
    reg [15:0] reverseTorqueLimit_reg;
    reg [15:0] directionSelect_reg;
    reg [15:0] feedbackPulseScale_reg;
    reg [15:0] ctrl_reg;
    reg [2:0]  irqStatus_reg;
    reg [2:0]  irqMask_reg;

    // Copies in force; only a reset moves new values in
    reg        dirActive_reg;
    reg [15:0] scaleActive_reg;

    wire [1:0] feedbackOutputSelect = ctrl_reg[`SFS_CTRL_OSEL_MSB:`SFS_CTRL_OSEL_LSB];
    wire       windowUnitSelect     = ctrl_reg[`SFS_CTRL_WUNIT];

    wire       wrTuning = regWr && (regAddr == `SFS_ADDR_TUNING);
    wire       wrWindow = regWr && (regAddr == `SFS_ADDR_WINDOW);
    wire       wrFwdLim = regWr && (regAddr == `SFS_ADDR_FWD_LIM);
    wire       wrRevLim = regWr && (regAddr == `SFS_ADDR_REV_LIM);
    wire       wrDir    = regWr && (regAddr == `SFS_ADDR_DIR);
    wire       wrScale  = regWr && (regAddr == `SFS_ADDR_FB_SCALE);
    wire       wrCtrl   = regWr && (regAddr == `SFS_ADDR_CTRL);
    wire       wrStat   = regWr && (regAddr == `SFS_ADDR_IRQ_STAT);
    wire       wrMask   = regWr && (regAddr == `SFS_ADDR_IRQ_MASK);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tuningResponse_reg     <= `SFS_RST_TUNING;
            inPositionWindow_reg   <= `SFS_RST_WINDOW;
            forwardTorqueLimit_reg <= `SFS_RST_TORQUE_LIM;
            reverseTorqueLimit_reg <= `SFS_RST_TORQUE_LIM;
            directionSelect_reg    <= `SFS_RST_DIR;
            feedbackPulseScale_reg <= `SFS_RST_FB_SCALE;
            ctrl_reg               <= `SFS_RST_CTRL;
            irqMask_reg            <= 3'h0;
        end else begin
            if (wrTuning)
                tuningResponse_reg <= regWrData[15:0];
            if (wrWindow)
                inPositionWindow_reg <= regWrData[15:0];
            if (wrFwdLim)
                forwardTorqueLimit_reg <= regWrData[15:0];
            if (wrRevLim)
                reverseTorqueLimit_reg <= regWrData[15:0];
            if (wrDir)
                directionSelect_reg <= regWrData[15:0];
            if (wrScale)
                feedbackPulseScale_reg <= regWrData[15:0];
            if (wrCtrl)
                ctrl_reg <= regWrData[15:0];
            if (wrMask)
                irqMask_reg <= regWrData[2:0];
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dirActive_reg   <= 1'b0;
            scaleActive_reg <= `SFS_RST_FB_SCALE;
        end else if (crstEvent) begin
            dirActive_reg   <= directionSelect_reg[0];
            scaleActive_reg <= feedbackPulseScale_reg;
        end
    end

    // ------------------------------------------------------------------
    // In-position window
    // ------------------------------------------------------------------
    reg  [31:0] devMag;

    always @* begin
        if (windowUnitSelect)
            devMag = encDeviation[31] ? (32'h0 - encDeviation) : encDeviation;
        else
            devMag = cmdDeviation[31] ? (32'h0 - cmdDeviation) : cmdDeviation;
    end

    // Unsigned magnitude, so the most negative deviation still folds
    wire inWindow = (devMag <= {16'h0, inPositionWindow_reg});

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inPositionFlag     <= 1'b0;
            movementFinishFlag <= 1'b0;
        end else begin
            inPositionFlag     <= inWindow;
            movementFinishFlag <= inWindow & ~fwdStart & ~revStart;
        end
    end

    // ------------------------------------------------------------------
    // Torque clamp and monitor
    // ------------------------------------------------------------------
    // Limits in tenths of a percent; zero blocks torque that way
    wire signed [16:0] fwdLimS = {1'b0, forwardTorqueLimit_reg};
    wire signed [16:0] revLimS = {1'b0, reverseTorqueLimit_reg};
    wire signed [16:0] tqS     = {torqueCmd[15], torqueCmd};
    reg  signed [16:0] tqClamped;
    reg                clampHit;

    always @* begin
        tqClamped = tqS;
        clampHit  = 1'b0;
        if (tqS > fwdLimS) begin
            tqClamped = fwdLimS;
            clampHit  = 1'b1;
        end
        if (tqS < -revLimS) begin
            tqClamped = -revLimS;
            clampHit  = 1'b1;
        end
    end

    wire [15:0] minLim  = (forwardTorqueLimit_reg < reverseTorqueLimit_reg) ?
                          forwardTorqueLimit_reg : reverseTorqueLimit_reg;
    wire signed [16:0] tqNeg   = -tqClamped;
    wire [15:0] tqMag   = tqClamped[16] ? tqNeg[15:0] : tqClamped[15:0];
    // Combinational divide; one-cycle path, a 32-bit product over a 16-bit limit zero-extended to 32 bits
    wire [31:0] monFull = ({16'h0, tqMag} * `SFS_MON_FULL) / {16'h0, minLim};
    // Full-scale code, cut to the monitor width below
    wire [31:0] monCeil = `SFS_MON_FULL;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            torqueOut     <= 16'sh0;
            torqueMonitor <= 16'h0;
        end else begin
            torqueOut <= tqClamped[15:0];
            if (minLim == 16'h0)
                torqueMonitor <= 16'h0;
            else if (monFull > `SFS_MON_FULL)
                torqueMonitor <= monCeil[15:0];
            else
                torqueMonitor <= monFull[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Start command direction mapping
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            motorRunCcw <= 1'b0;
            motorRunCw  <= 1'b0;
        end else begin
            motorRunCcw <= dirActive_reg ? (revStart & ~fwdStart) : (fwdStart & ~revStart);
            motorRunCw  <= dirActive_reg ? (fwdStart & ~revStart) : (revStart & ~fwdStart);
        end
    end

    // ------------------------------------------------------------------
    // Feedback pulse scaler
    // ------------------------------------------------------------------
    // Remainder kept, so the edge count never drifts over many turns
    reg  [18:0] acc_reg;
    reg  [15:0] divCnt_reg;
    reg  [1:0]  phase_reg;
    wire [18:0] accSum  = acc_reg + {3'h0, scaleActive_reg};
    reg         edgeNow;
    reg         edgeCcw;

    always @* begin
        edgeNow = 1'b0;
        edgeCcw = encStepCcw;
        case (feedbackOutputSelect)
            `SFS_OSEL_PULSE: edgeNow = encStep && (accSum >= `SFS_ENC_RES);
            // one edge per setting encoder edges
            `SFS_OSEL_DIVIDE: edgeNow = encStep &&
                              ({divCnt_reg + 16'h1} >= scaleActive_reg);
            `SFS_OSEL_COMMAND: begin
                edgeNow = cmdStep;
                edgeCcw = cmdStepCcw;
            end
            default: edgeNow = 1'b0;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg    <= 19'h0;
            divCnt_reg <= 16'h0;
            phase_reg  <= 2'h0;
            feedbackA  <= 1'b0;
            feedbackB  <= 1'b0;
        end else begin
            if (crstEvent) begin
                acc_reg    <= 19'h0;
                divCnt_reg <= 16'h0;
            end else if (encStep) begin
                if (accSum >= `SFS_ENC_RES)
                    acc_reg <= accSum - `SFS_ENC_RES;
                else
                    acc_reg <= accSum;
                if ({divCnt_reg + 16'h1} >= scaleActive_reg)
                    divCnt_reg <= 16'h0;
                else
                    divCnt_reg <= divCnt_reg + 16'h1;
            end
            // each edge is a quarter A/B cycle
            if (edgeNow) begin
                if (edgeCcw)
                    phase_reg <= phase_reg + 2'h1;
                else
                    phase_reg <= phase_reg - 2'h1;
            end
            feedbackA <= phase_reg[1];
            feedbackB <= phase_reg[1] ^ phase_reg[0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Only the rise of the window flag counts as an event
    reg        inPosLast_reg;
    wire [2:0] irqSet = {crstEvent, clampHit, inWindow & ~inPosLast_reg};

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inPosLast_reg <= 1'b0;
            irqStatus_reg <= 3'h0;
            irq           <= 1'b0;
        end else begin
            inPosLast_reg <= inWindow;
            // Set beats a same-cycle write-one clear
            irqStatus_reg <= irqSet | (irqStatus_reg & ~(wrStat ? regWrData[2:0] : 3'h0));
            irq           <= |(irqStatus_reg & irqMask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Zero outside the read cycle, so stale data never linger
    reg [31:0] rdMux;

    always @* begin
        case (regAddr)
            `SFS_ADDR_TUNING:   rdMux = {16'h0, tuningResponse_reg};
            `SFS_ADDR_WINDOW:   rdMux = {16'h0, inPositionWindow_reg};
            `SFS_ADDR_FWD_LIM:  rdMux = {16'h0, forwardTorqueLimit_reg};
            `SFS_ADDR_REV_LIM:  rdMux = {16'h0, reverseTorqueLimit_reg};
            `SFS_ADDR_DIR:      rdMux = {16'h0, directionSelect_reg};
            `SFS_ADDR_FB_SCALE: rdMux = {16'h0, feedbackPulseScale_reg};
            `SFS_ADDR_CTRL:     rdMux = {16'h0, ctrl_reg};
            `SFS_ADDR_STATE:    rdMux = {11'h0, scaleActive_reg, dirActive_reg,
                                         motorRunCw, motorRunCcw,
                                         movementFinishFlag, inPositionFlag};
            `SFS_ADDR_IRQ_STAT: rdMux = {29'h0, irqStatus_reg};
            `SFS_ADDR_IRQ_MASK: rdMux = {29'h0, irqMask_reg};
            default:            rdMux = 32'h0;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            regRdData <= 32'h0;
        else if (regRd)
            regRdData <= rdMux;
        else
            regRdData <= 32'h0;
    end

endmodule // sfs_servo_feedback

// *** tb/sfs_servo_feedback_properties.sv ***
// Port-level checks for the feedback scaling block.
// Assumes it is bound to sfs_servo_feedback and sees only its ports.
`timescale 1ns/1ps

module sfs_feedback_properties (
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic signed [31:0] cmdDeviation,
    input wire logic signed [31:0] encDeviation,
    input wire logic               encStep,
    input wire logic               cmdStep,
    input wire logic               forwardStartCmd,
    input wire logic               reverseStartCmd,
    input wire logic signed [15:0] torqueCmd,
    input wire logic signed [15:0] torqueOut,
    input wire logic [15:0]        torqueMonitor,
    input wire logic               inPositionFlag,
    input wire logic               movementFinishFlag,
    input wire logic               motorRunCcw,
    input wire logic               motorRunCw,
    input wire logic               feedbackA,
    input wire logic               feedbackB
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_zero_dev_inpos: assert property (
        cmdDeviation == 0 && encDeviation == 0 |=> inPositionFlag)
        else $error("in-position flag low at zero deviation");
    chk_finish_needs_inpos: assert property (
        movementFinishFlag |-> inPositionFlag)
        else $error("movement finish without in-position");
    chk_start_blocks_finish: assert property (
        forwardStartCmd [*4] |-> !movementFinishFlag)
        else $error("movement finish while a start is held");
    chk_torque_pos_bound: assert property (
        ($stable(torqueCmd) && torqueCmd >= 0) [*3] |-> torqueOut >= 0 && torqueOut <= torqueCmd)
        else $error("positive torque not clamped correctly");
    chk_torque_neg_bound: assert property (
        ($stable(torqueCmd) && torqueCmd <= 0) [*3] |-> torqueOut <= 0 && torqueOut >= torqueCmd)
        else $error("negative torque not clamped correctly");
    chk_monitor_range: assert property (
        torqueMonitor <= 16'h7fff)
        else $error("torque monitor above full scale");
    chk_run_exclusive: assert property (
        !(motorRunCcw && motorRunCw))
        else $error("motor runs both ways");
    chk_both_starts_stop: assert property (
        (forwardStartCmd && reverseStartCmd) [*4] |-> !motorRunCcw && !motorRunCw)
        else $error("motor runs with both starts held");
    chk_quad_one_bit: assert property (
        !($changed(feedbackA) && $changed(feedbackB)))
        else $error("both feedback phases moved at once");
    chk_fb_has_cause: assert property (
        $changed(feedbackA) || $changed(feedbackB) |-> $past(encStep, 2) || $past(cmdStep, 2))
        else $error("feedback edge without a step");
endmodule // sfs_feedback_properties

bind sfs_servo_feedback sfs_feedback_properties u_sfs_feedback_properties (
    .clock(clock), .rst_n(rst_n), .cmdDeviation(cmdDeviation), .encDeviation(encDeviation),
    .encStep(encStep), .cmdStep(cmdStep), .forwardStartCmd(forwardStartCmd),
    .reverseStartCmd(reverseStartCmd), .torqueCmd(torqueCmd), .torqueOut(torqueOut),
    .torqueMonitor(torqueMonitor), .inPositionFlag(inPositionFlag),
    .movementFinishFlag(movementFinishFlag), .motorRunCcw(motorRunCcw),
    .motorRunCw(motorRunCw), .feedbackA(feedbackA), .feedbackB(feedbackB));

// *** tb/sfs_ctrl_model.sv ***
// Positioning controller model: drives start levels, counts feedback.
// Assumes the clock of the block; starts change only after an edge.
`timescale 1ns/1ps

module sfs_ctrl_model (
    input  wire logic   clock,
    input  wire logic   rst_n,
    input  wire logic   fwdReq,
    input  wire logic   revReq,
    input  wire logic   feedbackA,
    input  wire logic   feedbackB,
    output logic        forwardStartCmd,
    output logic        reverseStartCmd,
    output logic signed [31:0] fbCount,
    output logic [7:0]  fbGlitches
);
    logic [1:0] prevIdx;
    logic [1:0] curIdx;

    // Gray phase to index; CCW steps count up
    assign curIdx = {feedbackA, feedbackA ^ feedbackB};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            forwardStartCmd <= 1'b0;
            reverseStartCmd <= 1'b0;
            prevIdx <= 2'h0;
            fbCount <= 32'sh0;
            fbGlitches <= 8'h0;
        end else begin
            forwardStartCmd <= fwdReq;
            reverseStartCmd <= revReq;
            prevIdx <= curIdx;
            case (curIdx - prevIdx)
                2'h1: fbCount <= fbCount + 1;
                2'h3: fbCount <= fbCount - 1;
                2'h2: fbGlitches <= fbGlitches + 8'h1;
                default: ;
            endcase
        end
    end
endmodule // sfs_ctrl_model

// *** tb/tb_top.sv ***
// Self-checking bench for the feedback scaling block.
// Assumes the register map and reset values of sfs_defines.vh.
`timescale 1ns/1ps
`include "sfs_defines.vh"

module tb_top;
    logic               clock, rst_n, regWr, regRd, encStep, encStepCcw, cmdStep, cmdStepCcw;
    logic               controllerReset, fwdReq, revReq, inPositionFlag, movementFinishFlag;
    logic               motorRunCcw, motorRunCw, feedbackA, feedbackB, irq;
    logic               forwardStartCmd, reverseStartCmd;
    logic [7:0]         regAddr, fbGlitches;
    logic [31:0]        regWrData, regRdData, rdVal;
    logic signed [31:0] cmdDeviation, encDeviation, fbCount, fbBase;
    logic signed [15:0] torqueCmd, torqueOut;
    logic [15:0]        torqueMonitor;
    int                 miscompares, testsRun, i, u;
    logic [7:0]  rstAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h3c};
    logic [31:0] rstExp [8] = '{32'h0c, 32'h64, 32'h3e8, 32'h3e8, 32'h0, 32'hfa0, 32'h0, 32'h0};
    logic signed [31:0] devs [4] = '{0, 6, -5, -6};
    logic signed [15:0] trq [5][4] = '{'{500, 200, 700, 500}, '{500, 200, -700, -200},
        '{500, 200, -100, -100}, '{0, 200, 300, 0}, '{500, 0, -50, 0}};

    sfs_servo_feedback u_sfs_servo_feedback (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .cmdDeviation(cmdDeviation), .encDeviation(encDeviation), .encStep(encStep),
        .encStepCcw(encStepCcw), .cmdStep(cmdStep), .cmdStepCcw(cmdStepCcw),
        .forwardStartCmd(forwardStartCmd), .reverseStartCmd(reverseStartCmd),
        .controllerReset(controllerReset), .torqueCmd(torqueCmd), .torqueOut(torqueOut),
        .torqueMonitor(torqueMonitor), .inPositionFlag(inPositionFlag),
        .movementFinishFlag(movementFinishFlag), .motorRunCcw(motorRunCcw),
        .motorRunCw(motorRunCw), .feedbackA(feedbackA), .feedbackB(feedbackB), .irq(irq));

    sfs_ctrl_model u_sfs_ctrl_model (.clock(clock), .rst_n(rst_n), .fwdReq(fwdReq),
        .revReq(revReq), .feedbackA(feedbackA), .feedbackB(feedbackB),
        .forwardStartCmd(forwardStartCmd), .reverseStartCmd(reverseStartCmd),
        .fbCount(fbCount), .fbGlitches(fbGlitches));

    always #10 clock = ~clock;

    // --------------------
    // Tasks
    // --------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic regWrite(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic readCheck(input string name, input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= addr;
        @(posedge clock);
        regRd <= 1'b0;
        #1 rdVal = regRdData;
        check(name, rdVal, exp);
    endtask
    task automatic waitCycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // steps 12 cycles apart keep the edge rate under the ceiling
    task automatic steps(input int n, input logic ccw, input logic useCmd);
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            encStep <= !useCmd;
            cmdStep <= useCmd;
            encStepCcw <= ccw;
            cmdStepCcw <= ccw;
            @(posedge clock);
            encStep <= 1'b0;
            cmdStep <= 1'b0;
            repeat (10) @(posedge clock);
        end
        waitCycles(4);
    endtask
    task automatic reload();
        @(posedge clock);
        controllerReset <= 1'b1;
        repeat (4) @(posedge clock);
        controllerReset <= 1'b0;
        waitCycles(6);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // --------------------
    // Sequence
    // --------------------
    initial begin
        {clock, rst_n, regWr, regRd, encStep, encStepCcw, cmdStep, cmdStepCcw} = '0;
        {controllerReset, fwdReq, revReq, regAddr, regWrData, torqueCmd} = '0;
        cmdDeviation = 1000;
        encDeviation = 1000;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) readCheck("reset value", rstAddr[i], rstExp[i]);
        readCheck("state at reset", `SFS_ADDR_STATE, 32'h0001f400);
        regWrite(`SFS_ADDR_TUNING, 32'd20);
        readCheck("tuning", `SFS_ADDR_TUNING, 32'd20);
        regWrite(`SFS_ADDR_WINDOW, 32'd5);
        for (u = 0; u < 2; u++) begin
            regWrite(`SFS_ADDR_CTRL, u << 2);
            for (i = 0; i < 4; i++) begin
                cmdDeviation <= u ? 32'sd0 : devs[i];
                encDeviation <= u ? devs[i] : 32'sd0;
                waitCycles(3);
                check("in position", inPositionFlag, !i[0]);
                check("finish", movementFinishFlag, !i[0]);
            end
        end
        cmdDeviation <= 1000;
        encDeviation <= 1000;
        regWrite(`SFS_ADDR_CTRL, 32'h0);
        for (i = 0; i < 5; i++) begin
            regWrite(`SFS_ADDR_FWD_LIM, 32'(trq[i][0]));
            regWrite(`SFS_ADDR_REV_LIM, 32'(trq[i][1]));
            torqueCmd <= trq[i][2];
            waitCycles(4);
            check("torque out", 32'(torqueOut), 32'(trq[i][3]));
        end
        regWrite(`SFS_ADDR_FWD_LIM, 32'd500);
        regWrite(`SFS_ADDR_REV_LIM, 32'd200);
        torqueCmd <= 16'sd200;
        waitCycles(4);
        check("monitor", torqueMonitor, 16'h7fff);
        torqueCmd <= 16'sd0;
        regWrite(`SFS_ADDR_FB_SCALE, 32'h8000);
        reload();
        readCheck("state scale", `SFS_ADDR_STATE, 32'h00100000);
        fbBase = fbCount;
        steps(64, 1'b1, 1'b0);
        check("pulse mode ccw", fbCount - fbBase, 32'd8);
        steps(64, 1'b0, 1'b0);
        check("pulse mode cw", fbCount - fbBase, 32'd0);
        regWrite(`SFS_ADDR_FB_SCALE, 32'h3);
        reload();
        regWrite(`SFS_ADDR_CTRL, 32'h1);
        fbBase = fbCount;
        steps(12, 1'b1, 1'b0);
        check("divide mode", fbCount - fbBase, 32'd4);
        regWrite(`SFS_ADDR_CTRL, 32'h2);
        fbBase = fbCount;
        steps(5, 1'b0, 1'b1);
        check("command mode", fbCount - fbBase, -32'sd5);
        regWrite(`SFS_ADDR_CTRL, 32'h3);
        fbBase = fbCount;
        steps(3, 1'b1, 1'b1);
        check("mode off", fbCount - fbBase, 32'd0);
        check("phase order", fbGlitches, 8'h0);
        cmdDeviation <= 0;
        fwdReq <= 1'b1;
        waitCycles(8);
        check("fwd ccw", {motorRunCcw, motorRunCw, movementFinishFlag}, 3'b100);
        regWrite(`SFS_ADDR_DIR, 32'h1);
        waitCycles(4);
        check("dir held", {motorRunCcw, motorRunCw}, 2'b10);
        reload();
        check("fwd cw", {motorRunCcw, motorRunCw}, 2'b01);
        fwdReq <= 1'b0;
        revReq <= 1'b1;
        waitCycles(8);
        check("rev ccw", {motorRunCcw, motorRunCw}, 2'b10);
        fwdReq <= 1'b1;
        waitCycles(8);
        check("both starts", {motorRunCcw, motorRunCw}, 2'b00);
        {fwdReq, revReq} <= 2'b00;
        readCheck("irq status", `SFS_ADDR_IRQ_STAT, 32'h7);
        check("irq masked", irq, 1'b0);
        regWrite(`SFS_ADDR_IRQ_MASK, 32'h1);
        waitCycles(2);
        check("irq raised", irq, 1'b1);
        check("finish after stop", movementFinishFlag, 1'b1);
        regWrite(`SFS_ADDR_IRQ_STAT, 32'h1);
        waitCycles(2);
        check("irq cleared", irq, 1'b0);
        readCheck("status left", `SFS_ADDR_IRQ_STAT, 32'h6);
        regWrite(`SFS_ADDR_IRQ_STAT, 32'h6);
        readCheck("status empty", `SFS_ADDR_IRQ_STAT, 32'h0);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
endmodule // tb_top
